// ---- hdl/tcc_pkg.sv ----
// shared constants for the triple comparator control block
package tcc_pkg;

  // ---------------------------------------------------------------
  // widths and types
  // ---------------------------------------------------------------
  localparam int NUM_CH = 3;
  typedef logic [31:0] tcc_addr_t;
  typedef logic [15:0] tcc_half_t;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam tcc_addr_t CH_CTRL_BASE = 32'h0000_0000;
  localparam tcc_addr_t CH_STRIDE = 32'h0000_0004;
  localparam tcc_addr_t SHARED_STATUS_OFS = 32'h0000_000C;
  localparam tcc_addr_t REF_CTRL_OFS = 32'h0000_0010;
  localparam tcc_addr_t INT_STATUS_OFS = 32'h0000_0014;
  localparam tcc_addr_t INT_CLEAR_OFS = 32'h0000_0018;
  localparam tcc_addr_t INT_ENABLE_OFS = 32'h0000_001C;

  // ---------------------------------------------------------------
  // channel control word fields
  // ---------------------------------------------------------------
  localparam int ON_BIT = 15;
  localparam int PINDRV_BIT = 14;
  localparam int INV_BIT = 13;
  localparam int EVT_BIT = 9;
  localparam int RES_BIT = 8;
  localparam int EDGE_LO = 6;
  localparam int PLUS_BIT = 4;
  localparam int MINUS_LO = 0;
  localparam tcc_half_t CTRL_WMASK = 16'hE0D3;
  localparam tcc_half_t CTRL_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // shared status and reference fields
  // ---------------------------------------------------------------
  localparam int IDLE_BIT = 15;
  localparam int STAT_EVT_LO = 8;
  localparam int STAT_RES_LO = 0;
  localparam int REFPIN_BIT = 10;
  localparam int BGSEL_LO = 8;
  localparam tcc_half_t REF_WMASK = 16'h0700;
  localparam tcc_half_t REF_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // event edge codes and bus codes
  // ---------------------------------------------------------------
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage : tcc_pkg

// ---- hdl/tcc_channel.sv ----
// one comparator channel: result synchroniser and event edge detection
`timescale 1ns/1ps
`default_nettype none

module tcc_channel (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rawResult,
  input wire logic active,
  input wire logic invert,
  input wire logic [1:0] edgeSelect,
  output logic result,
  output logic edgeHit
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [2:0] sync_q, sync_d;
  logic stable_q, stable_d;
  logic prevOut_q, prevOut_d;
  logic wasActive_q, wasActive_d;
  logic rise, fall;

  always_comb begin
    sync_d = {sync_q[1:0], rawResult};
    // a change counts once the second and third stages agree
    stable_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : stable_q;
    prevOut_d = result;
    wasActive_d = active;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync_q <= 3'h0;
      stable_q <= 1'b0;
      prevOut_q <= 1'b0;
      wasActive_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      stable_q <= stable_d;
      prevOut_q <= prevOut_d;
      wasActive_q <= wasActive_d;
    end
  end

  // ---------------------------------------------------------------
  // result and edge selection
  // ---------------------------------------------------------------
  assign result = active & (stable_q ^ invert);
  assign rise = active & wasActive_q & result & ~prevOut_q;
  assign fall = active & wasActive_q & ~result & prevOut_q;

  always_comb begin
    case (edgeSelect)
      tcc_pkg::EDGE_ANY: edgeHit = rise | fall;
      tcc_pkg::EDGE_FALL: edgeHit = invert ? rise : fall;
      tcc_pkg::EDGE_RISE: edgeHit = invert ? fall : rise;
      tcc_pkg::EDGE_NONE: edgeHit = 1'b0;
      default: edgeHit = 1'b0;
    endcase
  end

endmodule : tcc_channel

`default_nettype wire

// ---- hdl/tcc_ahb_port.sv ----
// AHB-Lite slave front end: zero wait states, registered read data
`timescale 1ns/1ps
`default_nettype none

module tcc_ahb_port (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] haddr,
  input wire logic [31:0] readData,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic wrEn,
  output logic [31:0] wrAddr
);

  logic accept;
  logic wrPend_q, wrPend_d;
  logic [31:0] wrAddr_q, wrAddr_d;
  logic [31:0] rdData_q, rdData_d;

  // ---------------------------------------------------------------
  // address phase capture
  // ---------------------------------------------------------------
  assign accept = hsel & htrans[1] & hready;

  always_comb begin
    wrPend_d = accept & hwrite & (hsize == tcc_pkg::HSIZE_WORD);
    wrAddr_d = wrPend_d ? haddr : wrAddr_q;
    rdData_d = (accept & ~hwrite) ? readData : rdData_q;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 32'h0000_0000;
      rdData_q <= 32'h0000_0000;
    end else begin
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      rdData_q <= rdData_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData_q;
  assign wrEn = wrPend_q;
  assign wrAddr = wrAddr_q;

endmodule : tcc_ahb_port

`default_nettype wire

// ---- hdl/tcc_top.sv ----
// triple comparator control: registers, event flags, interrupt, analog steering
`timescale 1ns/1ps
`default_nettype none


module tcc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [2:0] cmpRaw,
  input wire logic idleMode,
  output logic [2:0] comparatorOn,
  output logic [2:0] plusInputSelect,
  output logic [2:0][1:0] minusInputSelect,
  output logic referencePinSelect,
  output logic [1:0] bandgapSourceSelect,
  output logic [2:0] resultPin,
  output logic [2:0] resultPinOe,
  output logic [2:0] eventTrigger,
  output logic irq
);

  localparam int NCH = tcc_pkg::NUM_CH;

  // ---------------------------------------------------------------
  // address decode helpers
  // ---------------------------------------------------------------
  function automatic tcc_pkg::tcc_addr_t ctrlOffset(input int idx);
    tcc_pkg::tcc_addr_t step;
    step = tcc_pkg::CH_STRIDE * tcc_pkg::tcc_addr_t'(idx);
    return tcc_pkg::CH_CTRL_BASE + step;
  endfunction : ctrlOffset

  function automatic logic hitReg(input tcc_pkg::tcc_addr_t addr,
                                  input tcc_pkg::tcc_addr_t offs);
    return addr == offs;
  endfunction : hitReg

  // control word as software reads it back
  function automatic logic [15:0] channelWord(input logic [15:0] ctrl,
                                              input logic evt,
                                              input logic res);
    logic [15:0] w;
    w = ctrl;
    w[tcc_pkg::EVT_BIT] = evt;
    w[tcc_pkg::RES_BIT] = res;
    return w;
  endfunction : channelWord

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  logic wrEn;
  logic [31:0] wrAddr;
  logic [31:0] readData;
  logic [15:0] wrData;

  tcc_ahb_port u_ahb (
    .clk(clk),
    .reset_n(reset_n),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .haddr(haddr),
    .readData(readData),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wrEn(wrEn),
    .wrAddr(wrAddr)
  );

  assign wrData = hwdata[15:0];

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [NCH-1:0][15:0] ctrl_q, ctrl_d;
  logic [NCH-1:0] evt_q, evt_d;
  logic idleHalt_q, idleHalt_d;
  logic [15:0] refCtrl_q, refCtrl_d;
  logic [NCH-1:0] intStat_q, intStat_d;
  logic [NCH-1:0] intEn_q, intEn_d;
  logic [NCH-1:0] trig_q, trig_d;

  // ---------------------------------------------------------------
  // channel datapath
  // ---------------------------------------------------------------
  logic [NCH-1:0] active;
  logic [NCH-1:0] result;
  logic [NCH-1:0] edgeHit;
  logic [NCH-1:0] trig;
  logic idleStop;

  assign idleStop = idleHalt_q & idleMode;

  for (genvar g = 0; g < NCH; g++) begin : gChan
    assign active[g] = ctrl_q[g][tcc_pkg::ON_BIT] & ~idleStop;

    tcc_channel u_chan (
      .clk(clk),
      .reset_n(reset_n),
      .rawResult(cmpRaw[g]),
      .active(active[g]),
      .invert(ctrl_q[g][tcc_pkg::INV_BIT]),
      .edgeSelect(ctrl_q[g][tcc_pkg::EDGE_LO +: 2]),
      .result(result[g]),
      .edgeHit(edgeHit[g])
    );

    // a set event flag holds off further triggers
    assign trig[g] = edgeHit[g] & ~evt_q[g];

    assign comparatorOn[g] = active[g];
    assign plusInputSelect[g] = ctrl_q[g][tcc_pkg::PLUS_BIT];
    assign minusInputSelect[g] = ctrl_q[g][tcc_pkg::MINUS_LO +: 2];
    // pin path bypasses the synchroniser on purpose
    assign resultPin[g] = active[g] & (cmpRaw[g] ^ ctrl_q[g][tcc_pkg::INV_BIT]);
    assign resultPinOe[g] = active[g] & ctrl_q[g][tcc_pkg::PINDRV_BIT];
  end

  assign referencePinSelect = refCtrl_q[tcc_pkg::REFPIN_BIT];
  assign bandgapSourceSelect = refCtrl_q[tcc_pkg::BGSEL_LO +: 2];

  // ---------------------------------------------------------------
  // write strobes, one per writable register
  // ---------------------------------------------------------------
  logic [NCH-1:0] wrCtrl;
  logic wrStatus;
  logic wrRef;
  logic wrIntClear;
  logic wrIntEnable;

  for (genvar w = 0; w < NCH; w++) begin : gWrDec
    assign wrCtrl[w] = wrEn & hitReg(wrAddr, ctrlOffset(w));
  end

  assign wrStatus = wrEn & hitReg(wrAddr, tcc_pkg::SHARED_STATUS_OFS);
  assign wrRef = wrEn & hitReg(wrAddr, tcc_pkg::REF_CTRL_OFS);
  assign wrIntClear = wrEn & hitReg(wrAddr, tcc_pkg::INT_CLEAR_OFS);
  assign wrIntEnable = wrEn & hitReg(wrAddr, tcc_pkg::INT_ENABLE_OFS);

  // ---------------------------------------------------------------
  // channel control words
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    for (int i = 0; i < NCH; i++) begin
      if (wrCtrl[i]) begin
        ctrl_d[i] = wrData & tcc_pkg::CTRL_WMASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_q[i] <= tcc_pkg::CTRL_RESET;
      end
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------------------------------------------------------
  // event flags and trigger pulses
  // ---------------------------------------------------------------
  always_comb begin
    evt_d = evt_q;
    trig_d = trig;
    for (int i = 0; i < NCH; i++) begin
      if (wrCtrl[i]) begin
        evt_d[i] = wrData[tcc_pkg::EVT_BIT];
      end
      // hardware set wins over a software clear in the same cycle
      if (trig[i]) begin
        evt_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      evt_q <= 3'h0;
      trig_q <= 3'h0;
    end else begin
      evt_q <= evt_d;
      trig_q <= trig_d;
    end
  end

  // ---------------------------------------------------------------
  // idle halt and reference control
  // ---------------------------------------------------------------
  always_comb begin
    idleHalt_d = idleHalt_q;
    refCtrl_d = refCtrl_q;
    if (wrStatus) begin
      idleHalt_d = wrData[tcc_pkg::IDLE_BIT];
    end
    if (wrRef) begin
      refCtrl_d = wrData & tcc_pkg::REF_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      idleHalt_q <= 1'b0;
      refCtrl_q <= tcc_pkg::REF_RESET;
    end else begin
      idleHalt_q <= idleHalt_d;
      refCtrl_q <= refCtrl_d;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and enable
  // ---------------------------------------------------------------
  always_comb begin
    intStat_d = intStat_q;
    intEn_d = intEn_q;
    if (wrIntEnable) begin
      intEn_d = wrData[NCH-1:0];
    end
    if (wrIntClear) begin
      intStat_d = intStat_q & ~wrData[NCH-1:0];
    end
    // a new event wins over a clear in the same cycle
    intStat_d = intStat_d | trig;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      intStat_q <= 3'h0;
      intEn_q <= 3'h0;
    end else begin
      intStat_q <= intStat_d;
      intEn_q <= intEn_d;
    end
  end

  // ---------------------------------------------------------------
  // event and interrupt outputs
  // ---------------------------------------------------------------
  assign eventTrigger = trig_q;
  assign irq = |(intStat_q & intEn_q);

  // ---------------------------------------------------------------
  // read data, decoded in the address phase
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] word;
    word = 16'h0000;
    for (int i = 0; i < NCH; i++) begin
      if (hitReg(haddr, ctrlOffset(i))) begin
        word = channelWord(ctrl_q[i], evt_q[i], result[i]);
      end
    end
    if (hitReg(haddr, tcc_pkg::SHARED_STATUS_OFS)) begin
      word[tcc_pkg::IDLE_BIT] = idleHalt_q;
      word[tcc_pkg::STAT_EVT_LO +: 3] = evt_q;
      word[tcc_pkg::STAT_RES_LO +: 3] = result;
    end
    if (hitReg(haddr, tcc_pkg::REF_CTRL_OFS)) begin
      word = refCtrl_q;
    end
    if (hitReg(haddr, tcc_pkg::INT_STATUS_OFS)) begin
      word[NCH-1:0] = intStat_q;
    end
    if (hitReg(haddr, tcc_pkg::INT_ENABLE_OFS)) begin
      word[NCH-1:0] = intEn_q;
    end
    readData = {16'h0000, word};
  end

endmodule : tcc_top

`default_nettype wire

// ---- verification/tcc_analog_model.sv ----
// behavioural model of the three analog comparator cores
`timescale 1ns/1ps
`default_nettype none

module tcc_analog_model (
  input wire logic clk,
  input wire logic [2:0] comparatorOn,
  input wire logic [2:0] level,
  output logic [2:0] cmpRaw
);
  logic [2:0] noise = 3'h0;

  // a powered-down core gives a meaningless, changing output
  always @(posedge clk) noise <= ~noise;
  assign cmpRaw = (comparatorOn & level) | (~comparatorOn & noise);
endmodule : tcc_analog_model

`default_nettype wire

// ---- verification/tcc_checker_props.sv ----
// assertions on the triple comparator control ports
`timescale 1ns/1ps
`default_nettype none

module tcc_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [2:0] comparatorOn,
  input wire logic [2:0] resultPin,
  input wire logic [2:0] resultPinOe,
  input wire logic [2:0] eventTrigger,
  input wire logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic rdReq;
  logic wrReq;
  assign rdReq = hsel & htrans[1] & hready & !hwrite;
  assign wrReq = hsel & htrans[1] & hready & hwrite;

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_rdata_hold: assert property (!$past(rdReq) |-> $stable(hrdata))
    else $error("read data changed without a read");
  a_oe_gated: assert property ((resultPinOe & ~comparatorOn) == 3'h0)
    else $error("pin driven by an inactive channel");
  a_pin_gated: assert property ((resultPin & ~comparatorOn) == 3'h0)
    else $error("pin result from an inactive channel");
  a_trig_single: assert property (|eventTrigger |=> (eventTrigger & $past(eventTrigger)) == 3'h0)
    else $error("trigger repeated while flag set");
  a_trig_active: assert property ((eventTrigger & ~$past(comparatorOn)) == 3'h0)
    else $error("trigger from an inactive channel");
  a_irq_cause: assert property ($rose(irq) |-> (|eventTrigger) || $past(wrReq, 2))
    else $error("interrupt rose without event or write");
  a_irq_clear: assert property ($fell(irq) |-> $past(wrReq, 2))
    else $error("interrupt fell without a write");

  c_trigger: cover property (eventTrigger[0]);
  c_irq: cover property ($rose(irq));
  c_read: cover property (rdReq);
endmodule : tcc_checker

bind tcc_top tcc_checker tcc_checker_i (.clk(clk), .reset_n(reset_n), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .comparatorOn(comparatorOn), .resultPin(resultPin),
  .resultPinOe(resultPinOe), .eventTrigger(eventTrigger), .irq(irq));

`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the triple comparator control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, idleMode, refPin, irq;
  logic [1:0] htrans, bgSel;
  logic [2:0] hsize, cmpRaw, compOn, plusSel, resPin, resOe, evTrig, level;
  logic [2:0][1:0] minusSel;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] cfg;
  int error_cnt = 0;
  int comparisons = 0;
  int trigCnt = 0;
  int base;

  assign hready = hreadyout;
  tcc_top tcc_top_i (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmpRaw(cmpRaw),
    .idleMode(idleMode), .comparatorOn(compOn), .plusInputSelect(plusSel),
    .minusInputSelect(minusSel), .referencePinSelect(refPin),
    .bandgapSourceSelect(bgSel), .resultPin(resPin), .resultPinOe(resOe),
    .eventTrigger(evTrig), .irq(irq));
  tcc_analog_model tcc_analog_model_i (.clk(clk), .comparatorOn(compOn), .level(level),
    .cmpRaw(cmpRaw));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (evTrig[0] === 1'b1) trigCnt <= trigCnt + 1;

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= tcc_pkg::HSIZE_WORD;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // channel 0 off, input low, then armed with flags cleared
  task automatic arm(input logic [15:0] c);
    wr(tcc_pkg::CH_CTRL_BASE, 32'h0);
    level[0] <= 1'b0;
    wr(tcc_pkg::CH_CTRL_BASE, {16'h0, c});
    repeat (10) @(posedge clk);
    wr(tcc_pkg::CH_CTRL_BASE, {16'h0, c});
    wr(tcc_pkg::INT_CLEAR_OFS, 32'h7);
  endtask : arm

  task automatic step(input logic [15:0] c, input logic lvl, input int trg, input logic ev,
                      input logic clr);
    base = trigCnt;
    level[0] <= lvl;
    repeat (10) @(posedge clk);
    chk(trigCnt - base, trg);
    chk(irq, ev);
    rdchk(tcc_pkg::SHARED_STATUS_OFS, {ev, 7'h0, lvl ^ c[13]});
    rdchk(tcc_pkg::CH_CTRL_BASE, {c[15:10], ev, lvl ^ c[13], c[7:0]});
    if (clr) begin
      wr(tcc_pkg::CH_CTRL_BASE, {16'h0, c});
      wr(tcc_pkg::INT_CLEAR_OFS, 32'h7);
    end
  endtask : step

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    idleMode = 1'b0;
    level = 3'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) rdchk(i * 4, 32'h0);
    wr(32'h20, 32'hFFFF);
    rdchk(32'h20, 32'h0);
    wr(tcc_pkg::CH_STRIDE, 32'h7DFF);
    rdchk(tcc_pkg::CH_STRIDE, 32'h60D3);
    chk({compOn[1], resOe[1], plusSel[1], minusSel[1]}, 5'h07);
    wr(tcc_pkg::SHARED_STATUS_OFS, 32'hFFFF);
    rdchk(tcc_pkg::SHARED_STATUS_OFS, 32'h8000);
    wr(tcc_pkg::REF_CTRL_OFS, 32'hFFFF);
    rdchk(tcc_pkg::REF_CTRL_OFS, 32'h0700);
    chk({refPin, bgSel}, 3'h7);
    wr(tcc_pkg::SHARED_STATUS_OFS, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(32'h8, 32'h10 | k);
      @(posedge clk);
      chk({plusSel[2], minusSel[2]}, 3'h4 | k);
    end
    wr(tcc_pkg::INT_ENABLE_OFS, 32'h7);
    wr(32'h8, 32'h8040);
    level[2] <= 1'b1;
    repeat (10) @(posedge clk);
    rdchk(tcc_pkg::SHARED_STATUS_OFS, 32'h0404);
    rdchk(tcc_pkg::INT_STATUS_OFS, 32'h4);
    wr(32'h8, 32'h0);
    wr(tcc_pkg::INT_CLEAR_OFS, 32'h7);
    for (int inv = 0; inv < 2; inv++) begin
      for (int c = 0; c < 4; c++) begin
        cfg = {1'b1, 1'b0, inv[0], 5'h0, c[1:0], 6'h0};
        arm(cfg);
        step(cfg, 1'b1, c[0], c[0], 1'b1);
        step(cfg, 1'b0, c[1], c[1], 1'b1);
      end
    end
    arm(16'h80C0);
    step(16'h80C0, 1'b1, 1, 1'b1, 1'b0);
    wr(tcc_pkg::INT_ENABLE_OFS, 32'h0);
    @(posedge clk);
    chk(irq, 1'b0);
    rdchk(tcc_pkg::INT_STATUS_OFS, 32'h1);
    wr(tcc_pkg::INT_ENABLE_OFS, 32'h7);
    @(posedge clk);
    chk(irq, 1'b1);
    step(16'h80C0, 1'b0, 0, 1'b1, 1'b1);
    wr(tcc_pkg::CH_CTRL_BASE, 32'hE000);
    level[0] <= 1'b1;
    repeat (2) @(posedge clk);
    chk({resPin[0], resOe[0]}, 2'h1);
    wr(tcc_pkg::SHARED_STATUS_OFS, 32'h8000);
    idleMode <= 1'b1;
    repeat (2) @(posedge clk);
    chk({compOn[0], resOe[0]}, 2'h0);
    wr(tcc_pkg::SHARED_STATUS_OFS, 32'h0);
    @(posedge clk);
    chk({compOn[0], resOe[0]}, 2'h3);
    idleMode <= 1'b0;
    finish_test();
  end
endmodule : testbench

`default_nettype wire
